//--- include/sbcp_pkg.sv
// Constants, state codes and carrier types of the serial boot command interpreter
package sbcp_pkg;

	// ----------------------------------------------------------------
	// Link characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_X = 8'h58;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_L = 8'h4C;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_A_UP = 8'h41;
	localparam logic [7:0] CH_F_UP = 8'h46;
	localparam logic [7:0] CH_A_LO = 8'h61;
	localparam logic [7:0] CH_F_LO = 8'h66;
	localparam int UART_DATA_BITS = 8;
	localparam int UART_STOP_BITS = 2;

	// ----------------------------------------------------------------
	// Security and boot byte values
	// ----------------------------------------------------------------
	localparam logic [7:0] SSB_LEVEL0 = 8'hFF;
	localparam logic [7:0] SSB_LEVEL1 = 8'hFE;
	localparam logic [7:0] SSB_LEVEL2 = 8'hFC;
	localparam logic [7:0] BSB_DEFAULT = 8'hFF;
	localparam logic [7:0] SBV_DEFAULT = 8'hFC;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ----------------------------------------------------------------
	// Record types and sub-commands
	// ----------------------------------------------------------------
	localparam logic [7:0] REC_PROGRAM = 8'h00;
	localparam logic [7:0] REC_WRITE = 8'h03;
	localparam logic [7:0] REC_DISPLAY = 8'h04;
	localparam logic [7:0] REC_READ = 8'h05;
	localparam logic [7:0] WR_BLOCK_ERASE = 8'h01;
	localparam logic [7:0] WR_ERASE_BOOT = 8'h04;
	localparam logic [7:0] WR_SECURITY = 8'h05;
	localparam logic [7:0] WR_BOOT_BYTE = 8'h06;
	localparam logic [7:0] WR_FULL_ERASE = 8'h07;
	localparam logic [7:0] RD_IDENT = 8'h00;
	localparam logic [7:0] RD_BOOT = 8'h07;
	localparam logic [7:0] SEL_FIRST = 8'h00;
	localparam logic [7:0] SEL_SECOND = 8'h01;
	localparam logic [7:0] SEL_THIRD = 8'h02;
	localparam logic [7:0] DISP_BLANK = 8'h01;
	localparam int MAX_DATA = 128;
	localparam int PAGE_BYTES = 128;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_BAUD = 4'h8;
	localparam logic [3:0] REG_BOOT = 4'hC;
	localparam int CTRL_CHIP_ERASE = 0;

	typedef enum logic [6:0] {
		ST_OSC = 7'b0000001,
		ST_BAUD = 7'b0000010,
		ST_BAUD_END = 7'b0000100,
		ST_FRAME = 7'b0001000,
		ST_EXEC = 7'b0010000,
		ST_ERASE = 7'b0100000,
		ST_RESP = 7'b1000000
	} sbcp_state_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} sbcp_mem_t;

endpackage : sbcp_pkg

//--- logic/sbcp_top.sv
// Serial boot command interpreter: autobaud UART, hex record parser, security and erase engine
//
// Our own choices: the register offsets and the Avalon-MM slave port.
module sbcp_top #(
	parameter int FLASH_BYTES = 65536,
	parameter logic [7:0] ID_BYTE = 8'h5A // Arbitrary identity value
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic uart_rx,
	output logic uart_tx,
	input wire logic secondary_oscillator_active,
	input wire logic primary_oscillator_ready,
	output logic primary_oscillator_enable,
	output logic osc_select_primary,
	output sbcp_pkg::sbcp_mem_t flash_wr
);
	import sbcp_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= CH_ZERO && c <= CH_NINE) begin
			return {1'b1, c[3:0]};
		end else if ((c >= CH_A_UP && c <= CH_F_UP) || (c >= CH_A_LO && c <= CH_F_LO)) begin
			return {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return 5'h00;
	endfunction : hex_val

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'hA) ? 8'(CH_ZERO + {4'h0, n}) : 8'(CH_A_UP + {4'h0, n} - 8'h0A);
	endfunction : hex_char

	function automatic logic [23:0] line3(input logic [7:0] c);
		return {CH_LF, CH_CR, c};
	endfunction : line3

	function automatic logic [1:0] sec_level(input logic [7:0] s);
		if (s == SSB_LEVEL0) begin
			return 2'd0;
		end else if (s == SSB_LEVEL1) begin
			return 2'd1;
		end
		return 2'd2; // Any unknown pattern is treated as most secure
	endfunction : sec_level

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sbcp_state_t state_r;
	logic rx_s1, rx_s2, sec_s1, sec_s2, rdy_s1, rdy_s2;
	logic [1:0] osc_wait_r;
	logic prim_en_r, osc_sel_r;
	logic [15:0] bit_len_r;
	logic [16:0] ab_cnt_r;
	logic rx_busy_r, rx_valid_r;
	logic [15:0] rx_cnt_r;
	logic [3:0] rx_bit_r;
	logic [7:0] rx_sh_r, rx_byte_r;
	logic tx_busy_r, tx_r;
	logic [15:0] tx_cnt_r;
	logic [3:0] tx_n_r;
	logic [9:0] tx_sh_r;
	logic echo_pend_r;
	logic [7:0] echo_byte_r;
	logic tx_go, tx_echo;
	logic [7:0] tx_data;
	logic in_frame_r, hi_phase_r, chk_ok_r;
	logic [3:0] nib_hi_r;
	logic [8:0] idx_r;
	logic [7:0] len_r, type_r, sum_r;
	logic [15:0] addr_r;
	logic [7:0] data_mem [MAX_DATA];
	logic [4:0] cur_nib;
	logic [7:0] cur_byte;
	logic byte_done, data_we;
	logic [8:0] data_idx;
	logic [47:0] resp_buf_r;
	logic [2:0] resp_n_r;
	logic [7:0] ssb_r, bsb_r, sbv_r;
	logic [15:0] eng_addr_r, eng_last_r;
	logic [6:0] eng_idx_r;
	logic eng_fill_r, eng_full_r;
	logic erase_req_r, erase_take;
	sbcp_mem_t flash_wr_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [47:0] ex_buf;
	logic [2:0] ex_n;
	logic ex_eng, ex_fill, ex_full;
	logic [15:0] ex_start, ex_last;
	logic [7:0] ex_ssb, ex_bsb, ex_sbv;
	logic [1:0] lv;
	logic [7:0] refuse_ch, d0, d1, d2, rd_val;
	logic [8:0] page_end;

	assign uart_tx = tx_r;
	assign primary_oscillator_enable = prim_en_r;
	assign osc_select_primary = osc_sel_r;
	assign flash_wr = flash_wr_r;
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			sec_s1 <= 1'b0;
			sec_s2 <= 1'b0;
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
		end else begin
			rx_s1 <= uart_rx;
			rx_s2 <= rx_s1;
			sec_s1 <= secondary_oscillator_active;
			sec_s2 <= sec_s1;
			rdy_s1 <= primary_oscillator_ready;
			rdy_s2 <= rdy_s1;
		end
	end

	// ----------------------------------------------------------------
	// Receiver, one start, eight data, stop checked
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_busy_r <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_byte_r <= 8'h00;
		end else begin
			rx_valid_r <= 1'b0;
			if (state_r inside {ST_OSC, ST_BAUD, ST_BAUD_END}) begin
				rx_busy_r <= 1'b0;
			end else if (!rx_busy_r) begin
				if (!rx_s2) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r <= {1'b0, bit_len_r[15:1]}; // Sample mid-bit
					rx_bit_r <= 4'h0;
				end
			end else if (rx_cnt_r != 16'h0000) begin
				rx_cnt_r <= rx_cnt_r - 16'h0001;
			end else if (rx_bit_r == 4'h0) begin
				rx_busy_r <= !rx_s2; // Glitch shorter than half a bit is dropped
				rx_cnt_r <= bit_len_r - 16'h0001;
				rx_bit_r <= 4'h1;
			end else if (rx_bit_r <= 4'(UART_DATA_BITS)) begin
				rx_sh_r <= {rx_s2, rx_sh_r[7:1]};
				rx_cnt_r <= bit_len_r - 16'h0001;
				rx_bit_r <= rx_bit_r + 4'h1;
			end else begin
				rx_busy_r <= 1'b0;
				rx_valid_r <= rx_s2;
				rx_byte_r <= rx_sh_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmitter; echo outranks the response
	// ----------------------------------------------------------------
	assign tx_echo = echo_pend_r;
	assign tx_go = !tx_busy_r && (echo_pend_r || (state_r == ST_RESP && resp_n_r != 3'd0));
	assign tx_data = echo_pend_r ? echo_byte_r : resp_buf_r[7:0];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_busy_r <= 1'b0;
			tx_r <= 1'b1;
			tx_cnt_r <= 16'h0000;
			tx_n_r <= 4'h0;
			tx_sh_r <= 10'h3FF;
		end else if (tx_go) begin
			tx_busy_r <= 1'b1;
			tx_r <= 1'b0;
			tx_sh_r <= {{UART_STOP_BITS{1'b1}}, tx_data};
			tx_n_r <= 4'(UART_DATA_BITS + UART_STOP_BITS);
			tx_cnt_r <= bit_len_r - 16'h0001;
		end else if (tx_busy_r) begin
			if (tx_cnt_r != 16'h0000) begin
				tx_cnt_r <= tx_cnt_r - 16'h0001;
			end else if (tx_n_r == 4'h0) begin
				tx_busy_r <= 1'b0;
			end else begin
				tx_r <= tx_sh_r[0];
				tx_sh_r <= {1'b1, tx_sh_r[9:1]};
				tx_n_r <= tx_n_r - 4'h1;
				tx_cnt_r <= bit_len_r - 16'h0001;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			echo_pend_r <= 1'b0;
			echo_byte_r <= 8'h00;
		end else if (rx_valid_r) begin
			echo_pend_r <= 1'b1;
			echo_byte_r <= rx_byte_r;
		end else if (tx_go && tx_echo) begin
			echo_pend_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Record parser datapath
	// ----------------------------------------------------------------
	always_comb begin
		cur_nib = hex_val(rx_byte_r);
		cur_byte = {nib_hi_r, cur_nib[3:0]};
		byte_done = state_r == ST_FRAME && rx_valid_r && in_frame_r && rx_byte_r != CH_COLON
			&& cur_nib[4] && !hi_phase_r;
		data_idx = idx_r - 9'd4;
		data_we = byte_done && idx_r >= 9'd4 && idx_r < {1'b0, len_r} + 9'd4
			&& data_idx < 9'(MAX_DATA);
	end

	always_ff @(posedge clock) begin
		if (data_we) begin
			data_mem[data_idx[6:0]] <= cur_byte;
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	always_comb begin
		d0 = data_mem[0];
		d1 = data_mem[1];
		d2 = data_mem[2];
		lv = sec_level(ssb_r);
		refuse_ch = (lv == 2'd1) ? CH_P : CH_L;
		page_end = {2'b00, addr_r[6:0]} + {1'b0, len_r};
		rd_val = ID_BYTE;
		ex_buf = {24'h000000, line3(CH_DOT)};
		ex_n = 3'd3;
		ex_eng = 1'b0;
		ex_fill = 1'b1;
		ex_full = 1'b0;
		ex_start = 16'h0000;
		ex_last = 16'h0000;
		ex_ssb = ssb_r;
		ex_bsb = bsb_r;
		ex_sbv = sbv_r;
		if (!chk_ok_r) begin
			ex_buf = {24'h000000, line3(CH_X)};
		end else begin
			case (type_r)
				REC_PROGRAM: begin
					if (lv != 2'd0) begin
						ex_buf = {24'h000000, line3(refuse_ch)};
					end else if (len_r > 8'(MAX_DATA) || page_end > 9'(PAGE_BYTES)) begin
						ex_buf = {24'h000000, line3(CH_X)};
					end else if (len_r != 8'h00) begin
						ex_eng = 1'b1;
						ex_fill = 1'b0;
						ex_start = addr_r;
						ex_last = addr_r + {8'h00, len_r} - 16'h0001;
					end
				end
				REC_WRITE: begin
					case (d0)
						WR_BLOCK_ERASE: begin
							if (lv != 2'd0) begin
								ex_buf = {24'h000000, line3(refuse_ch)};
							end else begin
								ex_eng = 1'b1;
								ex_start = {d1, 8'h00};
								case (d1)
									8'h00: ex_last = 16'h1FFF;
									8'h20: ex_last = 16'h3FFF;
									8'h40: ex_last = 16'h7FFF;
									8'h80: ex_last = 16'hBFFF;
									default: ex_last = 16'hFFFF;
								endcase
							end
						end
						WR_ERASE_BOOT, WR_BOOT_BYTE: begin
							if (lv != 2'd0) begin
								ex_buf = {24'h000000, line3(refuse_ch)};
							end else if (d0 == WR_ERASE_BOOT) begin
								ex_bsb = ERASED_BYTE;
								ex_sbv = ERASED_BYTE;
							end else if (d1 == SEL_FIRST) begin
								ex_bsb = d2;
							end else if (d1 == SEL_SECOND) begin
								ex_sbv = d2;
							end
						end
						WR_SECURITY: begin
							// Only moves upward; a lowering request answers but changes nothing
							if (d1 == SEL_FIRST && lv == 2'd0) begin
								ex_ssb = SSB_LEVEL1;
							end else if (d1 == SEL_SECOND && lv != 2'd2) begin
								ex_ssb = SSB_LEVEL2;
							end
						end
						WR_FULL_ERASE: begin
							ex_eng = 1'b1;
							ex_full = 1'b1;
							ex_last = 16'(FLASH_BYTES - 1);
						end
						default: ;
					endcase
				end
				REC_DISPLAY: begin
					if (lv == 2'd2 && data_mem[4] != DISP_BLANK) begin
						ex_buf = {24'h000000, line3(CH_L)};
					end
				end
				REC_READ: begin
					if (d0 == RD_BOOT) begin
						rd_val = (d1 == SEL_FIRST) ? ssb_r : (d1 == SEL_SECOND) ? bsb_r : sbv_r;
					end
					if (d0 == RD_BOOT && d1 != SEL_FIRST && lv == 2'd2) begin
						ex_buf = {24'h000000, line3(CH_L)};
					end else begin
						ex_buf = {8'h00, CH_LF, CH_CR, CH_DOT, hex_char(rd_val[3:0]),
							hex_char(rd_val[7:4])};
						ex_n = 3'd5;
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Main sequencer
	// ----------------------------------------------------------------
	assign erase_take = state_r == ST_FRAME && !in_frame_r && erase_req_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= ST_OSC;
			osc_wait_r <= 2'd0;
			prim_en_r <= 1'b0;
			osc_sel_r <= 1'b0;
			bit_len_r <= 16'h0001;
			ab_cnt_r <= 17'h00000;
			in_frame_r <= 1'b0;
			hi_phase_r <= 1'b1;
			chk_ok_r <= 1'b0;
			nib_hi_r <= 4'h0;
			idx_r <= 9'd0;
			len_r <= 8'h00;
			type_r <= 8'h00;
			sum_r <= 8'h00;
			addr_r <= 16'h0000;
			resp_buf_r <= 48'h000000000000;
			resp_n_r <= 3'd0;
			ssb_r <= SSB_LEVEL0;
			bsb_r <= BSB_DEFAULT;
			sbv_r <= SBV_DEFAULT;
			eng_addr_r <= 16'h0000;
			eng_last_r <= 16'h0000;
			eng_idx_r <= 7'd0;
			eng_fill_r <= 1'b1;
			eng_full_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_OSC: begin
					// Two synchroniser stages must fill before the strap is trusted
					if (osc_wait_r != 2'd3) begin
						osc_wait_r <= osc_wait_r + 2'd1;
					end else if (!sec_s2) begin
						state_r <= ST_BAUD;
					end else begin
						prim_en_r <= 1'b1;
						if (rdy_s2) begin
							osc_sel_r <= 1'b1;
							state_r <= ST_BAUD;
						end
					end
				end
				ST_BAUD: begin
					// Start bit of the opening character is one bit time low
					if (!rx_s2) begin
						ab_cnt_r <= ab_cnt_r + 17'd1;
					end else if (ab_cnt_r != 17'd0) begin
						bit_len_r <= (ab_cnt_r[16] != 1'b0) ? 16'hFFFF : ab_cnt_r[15:0];
						ab_cnt_r <= 17'd0;
						state_r <= ST_BAUD_END;
					end
				end
				ST_BAUD_END: begin
					// The rest of the opening character never idles two bit times
					ab_cnt_r <= rx_s2 ? ab_cnt_r + 17'd1 : 17'd0;
					if (ab_cnt_r == {bit_len_r, 1'b0}) begin
						state_r <= ST_FRAME;
					end
				end
				ST_FRAME: begin
					if (erase_take) begin
						eng_addr_r <= 16'h0000;
						eng_last_r <= 16'(FLASH_BYTES - 1);
						eng_fill_r <= 1'b1;
						eng_full_r <= 1'b1;
						resp_n_r <= 3'd0;
						state_r <= ST_ERASE;
					end else if (rx_valid_r) begin
						if (rx_byte_r == CH_COLON) begin
							in_frame_r <= 1'b1;
							hi_phase_r <= 1'b1;
							idx_r <= 9'd0;
							sum_r <= 8'h00;
						end else if (in_frame_r) begin
							if (!cur_nib[4]) begin
								in_frame_r <= 1'b0; // Stray character drops the frame
							end else if (hi_phase_r) begin
								nib_hi_r <= cur_nib[3:0];
								hi_phase_r <= 1'b0;
							end else begin
								hi_phase_r <= 1'b1;
								sum_r <= sum_r + cur_byte;
								idx_r <= idx_r + 9'd1;
								case (idx_r)
									9'd0: len_r <= cur_byte;
									9'd1: addr_r[15:8] <= cur_byte;
									9'd2: addr_r[7:0] <= cur_byte;
									9'd3: type_r <= cur_byte;
									default: ;
								endcase
								if (idx_r == {1'b0, len_r} + 9'd4 && idx_r >= 9'd4) begin
									in_frame_r <= 1'b0;
									chk_ok_r <= 8'(sum_r + cur_byte) == 8'h00;
									state_r <= ST_EXEC;
								end
							end
						end
					end
				end
				ST_EXEC: begin
					resp_buf_r <= ex_buf;
					resp_n_r <= ex_n;
					ssb_r <= ex_ssb;
					bsb_r <= ex_bsb;
					sbv_r <= ex_sbv;
					eng_addr_r <= ex_start;
					eng_last_r <= ex_last;
					eng_idx_r <= 7'd0;
					eng_fill_r <= ex_fill;
					eng_full_r <= ex_full;
					state_r <= ex_eng ? ST_ERASE : ST_RESP;
				end
				ST_ERASE: begin
					eng_addr_r <= eng_addr_r + 16'h0001;
					eng_idx_r <= eng_idx_r + 7'd1;
					if (eng_addr_r == eng_last_r) begin
						if (eng_full_r) begin
							ssb_r <= SSB_LEVEL0;
							bsb_r <= BSB_DEFAULT;
							sbv_r <= SBV_DEFAULT;
						end
						state_r <= ST_RESP;
					end
				end
				ST_RESP: begin
					if (tx_go && !tx_echo) begin
						resp_buf_r <= {8'h00, resp_buf_r[47:8]};
						resp_n_r <= resp_n_r - 3'd1;
					end else if (resp_n_r == 3'd0 && !tx_busy_r && !echo_pend_r) begin
						state_r <= ST_FRAME;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flash write port; engine addresses are driven without any check against FLASH_BYTES
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flash_wr_r <= '0;
		end else begin
			flash_wr_r.we <= state_r == ST_ERASE;
			flash_wr_r.addr <= eng_addr_r;
			flash_wr_r.data <= eng_fill_r ? ERASED_BYTE : data_mem[eng_idx_r];
		end
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait cycle per access
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
			erase_req_r <= 1'b0;
		end else begin
			wait_r <= !((avs_read || avs_write) && wait_r);
			if (avs_write && !wait_r && avs_address == REG_CTRL
				&& avs_writedata[CTRL_CHIP_ERASE]) begin
				erase_req_r <= 1'b1;
			end else if (erase_take) begin
				erase_req_r <= 1'b0;
			end
			if (avs_read && wait_r) begin
				case (avs_address)
					REG_CTRL: rdata_r <= {31'h00000000, erase_req_r};
					REG_STATUS: rdata_r <= {21'h000000, osc_sel_r, prim_en_r, lv, state_r};
					REG_BAUD: rdata_r <= {16'h0000, bit_len_r};
					REG_BOOT: rdata_r <= {8'h00, sbv_r, bsb_r, ssb_r};
					default: rdata_r <= 32'h00000000;
				endcase
			end
		end
	end

endmodule : sbcp_top

//--- bench/sbcp_assertions.sv
// Port-level checker of the serial boot command interpreter
module sbcp_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic uart_rx,
	input wire logic uart_tx,
	input wire logic secondary_oscillator_active,
	input wire logic primary_oscillator_ready,
	input wire logic primary_oscillator_enable,
	input wire logic osc_select_primary,
	input wire sbcp_pkg::sbcp_mem_t flash_wr
);
	import sbcp_pkg::*;
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	logic rx_seen_r;
	// Remembers the first low on the line, so silence before it can be checked
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_seen_r <= 1'b0;
		end else if (!uart_rx) begin
			rx_seen_r <= 1'b1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_answer_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h2
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	chk_quiet_tx: assert property (!rx_seen_r |-> uart_tx)
		else $error("transmit before autobaud");
	chk_osc_enable: assert property (osc_select_primary |-> primary_oscillator_enable)
		else $error("primary selected while disabled");
	chk_osc_ready: assert property ($rose(osc_select_primary) |-> $past(primary_oscillator_ready, 2))
		else $error("primary selected before ready");
	chk_flash_ascend: assert property (flash_wr.we && $past(flash_wr.we)
		|-> flash_wr.addr == $past(flash_wr.addr) + 16'h1) else $error("flash address skipped");
	chk_erase_start: assert property (avs_write && !avs_waitrequest && avs_address == REG_CTRL
		&& avs_writedata[CTRL_CHIP_ERASE] |-> ##[1:300] (flash_wr.we && flash_wr.addr == 16'h0
		&& flash_wr.data == ERASED_BYTE)) else $error("chip erase did not start");
endmodule : sbcp_assertions

bind sbcp_top sbcp_assertions i_sbcp_assertions (.clock(clock), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .uart_rx(uart_rx), .uart_tx(uart_tx),
	.secondary_oscillator_active(secondary_oscillator_active),
	.primary_oscillator_ready(primary_oscillator_ready),
	.primary_oscillator_enable(primary_oscillator_enable),
	.osc_select_primary(osc_select_primary), .flash_wr(flash_wr));

//--- bench/sbcp_host_model.sv
// Host programming tool model: sends characters and collects replies
module sbcp_host_model #(
	parameter int BIT_LEN = 16
) (
	input wire logic clock,
	output logic line_out,
	input wire logic line_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	initial line_out = 1'b1;
	// Start, 8 data LSB first, two stops, no parity
	task automatic send_char(input logic [7:0] c);
		logic [10:0] f;
		f = {2'b11, c, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_out <= f[i];
			repeat (BIT_LEN) @(posedge clock);
		end
	endtask : send_char
	// Samples mid-bit, so a slightly off measured bit length still decodes
	initial begin : rx_loop
		logic [7:0] c;
		forever begin
			@(posedge clock);
			if (line_in === 1'b0) begin
				repeat (BIT_LEN / 2) @(posedge clock);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT_LEN) @(posedge clock);
					c[i] = line_in;
				end
				repeat (BIT_LEN) @(posedge clock);
				got_q.push_back(c);
			end
		end
	end
endmodule : sbcp_host_model

//--- bench/sbcp_top_tb.sv
// Testbench of the serial boot command interpreter
module sbcp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sbcp_pkg::*;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
		$display("unexpected at %0t: %h instead of %h", $time, a, b); end end
	localparam int BIT_LEN = 16;
	logic clock, rst, avs_read, avs_write, avs_waitrequest, uart_rx, uart_tx;
	logic sec_active, prim_ready, prim_en, sel_prim;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	sbcp_mem_t flash_wr, last_wr;
	int err_total, checked, wr_count, cycles, base;
	sbcp_top #(.FLASH_BYTES(256)) i_sbcp_top (.clock(clock), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .uart_rx(uart_rx), .uart_tx(uart_tx),
		.secondary_oscillator_active(sec_active), .primary_oscillator_ready(prim_ready),
		.primary_oscillator_enable(prim_en), .osc_select_primary(sel_prim), .flash_wr(flash_wr));
	sbcp_host_model #(.BIT_LEN(BIT_LEN)) i_sbcp_host_model (.clock(clock),
		.line_out(uart_rx), .line_in(uart_tx));
	// ----------------------------------------------------------------
	// Clock, flash monitor, timeout
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (flash_wr.we === 1'b1) begin
			wr_count++;
			last_wr = flash_wr;
		end
		if (cycles == 60000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	// Sends a whole frame, then waits out echo plus reply before comparing
	task automatic frame(input string s, input string r);
		int n;
		logic [7:0] e;
		i_sbcp_host_model.got_q.delete();
		@(posedge clock);
		for (int i = 0; i < s.len(); i++) i_sbcp_host_model.send_char(s[i]);
		n = 0;
		while (i_sbcp_host_model.got_q.size() < s.len() + r.len() && n < 5000) begin
			@(posedge clock);
			n++;
		end
		for (int i = 0; i < s.len() + r.len(); i++) begin
			e = (i < s.len()) ? s[i] : r[i - s.len()];
			`CHK(i_sbcp_host_model.got_q[i], e)
		end
		repeat (2 * BIT_LEN) @(posedge clock);
	endtask : frame
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_osc_baud;
		repeat (30) @(posedge clock);
		`CHK({prim_en, sel_prim}, 2'b10)
		prim_ready <= 1'b1;
		repeat (10) @(posedge clock);
		`CHK(sel_prim, 1'b1)
		i_sbcp_host_model.send_char(8'h55);
		repeat (4 * BIT_LEN) @(posedge clock);
		av(1'b0, REG_BAUD, 32'h0);
		`CHK((rd[15:0] inside {BIT_LEN - 1, BIT_LEN, BIT_LEN + 1}), 1'b1)
		av(1'b0, REG_STATUS, 32'h0);
		`CHK(rd, 32'h00000608)
		av(1'b0, 4'h2, 32'h0);
		`CHK(rd, 32'h0)
		$display("osc and autobaud test done");
	endtask : t_osc_baud
	task automatic t_prog;
		base = wr_count;
		frame(":01001000559A", ".\015\012");
		`CHK(last_wr, {1'b1, 16'h0010, 8'h55})
		frame(":010010005599", "X\015\012");
		frame(":02007F00AABB1A", "X\015\012");
		`CHK(wr_count, base + 1)
		$display("program and checksum test done");
	endtask : t_prog
	task automatic t_secure;
		base = wr_count;
		frame(":020000030500F6", ".\015\012");
		av(1'b0, REG_BOOT, 32'h0);
		`CHK(rd[7:0], SSB_LEVEL1)
		frame(":020000050700F2", "FE.\015\012");
		frame(":020000030100FA", "P\015\012");
		frame(":01001000559A", "P\015\012");
		frame(":020000030501F5", ".\015\012");
		frame(":020000030500F6", ".\015\012");
		av(1'b0, REG_BOOT, 32'h0);
		`CHK(rd[7:0], SSB_LEVEL2)
		frame(":01001000559A", "L\015\012");
		`CHK(wr_count, base)
		$display("security test done");
	endtask : t_secure
	task automatic t_erase;
		base = wr_count;
		av(1'b1, REG_CTRL, 32'h1);
		for (int n = 0; n < 2000 && wr_count < base + 256; n++) @(posedge clock);
		repeat (20) @(posedge clock);
		`CHK(wr_count, base + 256)
		`CHK(last_wr, {1'b1, 16'h00FF, ERASED_BYTE})
		av(1'b0, REG_BOOT, 32'h0);
		`CHK(rd[23:0], {SBV_DEFAULT, BSB_DEFAULT, SSB_LEVEL0})
		frame(":01001000559A", ".\015\012");
		$display("chip erase test done");
	endtask : t_erase
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		sec_active = 1'b1;
		prim_ready = 1'b0;
		{err_total, checked, wr_count, cycles} = '0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_osc_baud();
		t_prog();
		t_secure();
		t_erase();
		give_verdict();
	end
endmodule : sbcp_top_tb
